/* File: hw/fws_host.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// RQ1: Device pulls ready-busy low while algorithm runs.
// RQ2: Ready-busy valid from last write-enable rise.
// RQ3: Toggle bit one flips per read while busy.
// RQ4: Read delimited by output-enable or chip-enable.
// RQ5: All-protected erase toggles about 100 us.
// RQ6: Partly protected erase skips protected sectors.
// RQ7: Protected program target toggles about 1 us.
// RQ8: Erase suspend stops toggle bit one.
// RQ9: Erase-suspend-program toggles until program finishes.
// RQ10: Toggle bit one valid from command end.
// RQ11: Toggle bit two toggles in erase-selected sectors.
// RQ12: Host reads twice, equal toggle means done.
// RQ13: Toggling with timing flag: recheck, then reset.
// RQ14: Resumed polling restarts from double read.
// RQ15: Device sets timing flag past pulse limit.
// RQ16: Programming zero to one may hit limit.
// RQ17: Host writes reset after timing failure.
// RQ18: Erase timer flag low during acceptance window.
// RQ19: Fast successive erases need no timer check.
// RQ20: Timer flag high means commands ignored.
// RQ21: Host checks timer flag around extra erases.
// RQ22: Data poll bit shows complement while busy.
// RQ23: Buffer busy or abort keeps toggling.
// RQ24: Undefined status bits stay stable.
module fws_host
    import fws_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins.
    output logic [21:0] flashAddr,
    output logic [15:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [15:0] flashDqIn,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    input wire logic readyBusyN
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic [21:0] addrReg;
    logic [15:0] wdataReg;
    logic [15:0] rdataReg;
    logic pollActive;
    logic abortPend;
    logic [1:0] pollStep;
    logic prevToggle;
    logic done;
    logic fail;
    logic timingSeen;
    fws_bus_type busState;
    fws_op_type nextOp;
    logic [7:0] cnt;
    logic [15:0] wrBusData;
    logic doWrite;
    logic wrCtrl;
    logic busy;
    logic [31:0] statusWord;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    assign busy = busState != BUS_IDLE;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign wrCtrl = doWrite && awAddr == REG_CTRL && wStrb[0];
    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign s_axi_arready = !s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are held separately and joined here.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !awHeld)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr == REG_CTRL || awAddr == REG_ADDR || awAddr == REG_WDATA)
                begin
                    s_axi_bresp <= RESP_OKAY;
                end
                else
                begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Address and data only change while the flash bus is idle, so a cycle in flight is safe.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addrReg <= 22'h00_0000;
            wdataReg <= 16'h0000;
        end
        else if (doWrite && !busy)
        begin
            if (awAddr == REG_ADDR)
            begin
                addrReg <= wData[21:0];
            end
            else if (awAddr == REG_WDATA)
            begin
                wdataReg <= wData[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel.
    assign statusWord = {24'h00_0000,
        rdataReg[DQ_DATA_POLL], rdataReg[DQ_BUFFER_ABORT], timingSeen, readyBusyN,
        rdataReg[DQ_ERASE_TIMER], fail, done, busy}; // [RQ19] [RQ21]

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        if (s_axi_araddr == REG_CTRL)
        begin
            next_rdata = 32'h0000_0000;
        end
        else if (s_axi_araddr == REG_ADDR)
        begin
            next_rdata = {10'h000, addrReg};
        end
        else if (s_axi_araddr == REG_WDATA)
        begin
            next_rdata = {16'h0000, wdataReg};
        end
        else if (s_axi_araddr == REG_STATUS)
        begin
            next_rdata = statusWord;
        end
        else if (s_axi_araddr == REG_RDATA)
        begin
            next_rdata = {16'h0000, rdataReg};
        end
        else
        begin
            next_rresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // An abort may come at any point of a read, so it is held until that read ends.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            abortPend <= 1'b0;
        end
        else if (wrCtrl && wData[CTRL_ABORT] && pollActive)
        begin
            abortPend <= 1'b1;
        end
        else if (!pollActive)
        begin
            abortPend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flash bus sequencer and toggle polling.
    // Every read drops both strobes and raises both again, so it counts whichever strobe
    // the device watches. [RQ4]
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busState <= BUS_IDLE;
            nextOp <= OP_NONE;
            cnt <= 8'h00;
            pollActive <= 1'b0;
            pollStep <= 2'h0;
            prevToggle <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            timingSeen <= 1'b0;
            rdataReg <= 16'h0000;
            wrBusData <= 16'h0000;
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            flashWeN <= 1'b1;
            flashDqOe <= 1'b0;
        end
        else
        begin
            case (busState)
                BUS_IDLE:
                begin
                    cnt <= 8'h00;
                    if (wrCtrl && wData[CTRL_POLL])
                    begin
                        // A fresh start always begins with the double read. [RQ14]
                        pollActive <= 1'b1;
                        pollStep <= 2'h0;
                        done <= 1'b0;
                        fail <= 1'b0;
                        timingSeen <= 1'b0;
                        busState <= BUS_READ;
                        flashCeN <= 1'b0;
                        flashOeN <= 1'b0;
                    end
                    else if (wrCtrl && wData[CTRL_READ])
                    begin
                        done <= 1'b0;
                        busState <= BUS_READ;
                        flashCeN <= 1'b0;
                        flashOeN <= 1'b0;
                    end
                    else if (wrCtrl && wData[CTRL_WRITE])
                    begin
                        done <= 1'b0;
                        wrBusData <= wdataReg;
                        busState <= BUS_WRITE;
                        flashCeN <= 1'b0;
                        flashWeN <= 1'b0;
                        flashDqOe <= 1'b1;
                    end
                end
                BUS_READ:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt == RD_CYC - 8'h01)
                    begin
                        cnt <= 8'h00;
                        flashCeN <= 1'b1;
                        flashOeN <= 1'b1;
                        rdataReg <= flashDqIn;
                        busState <= BUS_GAP;
                        nextOp <= OP_NONE;
                        if (!pollActive)
                        begin
                            done <= 1'b1;
                        end
                        else if (abortPend || (wrCtrl && wData[CTRL_ABORT]))
                        begin
                            pollActive <= 1'b0; // [RQ14]
                        end
                        else if (pollStep == 2'h0)
                        begin
                            // First of the two back-to-back reads. [RQ12]
                            prevToggle <= flashDqIn[DQ_TOGGLE_ONE];
                            pollStep <= 2'h1;
                            nextOp <= OP_READ;
                        end
                        else if (flashDqIn[DQ_TOGGLE_ONE] == prevToggle)
                        begin
                            // No toggle: finished; the next read gives array data. [RQ12]
                            pollActive <= 1'b0;
                            done <= 1'b1;
                        end
                        else if (pollStep == 2'h2)
                        begin
                            // Still toggling after the timing flag: failed, so reset. [RQ13] [RQ17]
                            pollActive <= 1'b0;
                            fail <= 1'b1;
                            wrBusData <= CMD_RESET;
                            nextOp <= OP_WRITE;
                        end
                        else
                        begin
                            // Timing flag high calls for one more comparison. [RQ13]
                            prevToggle <= flashDqIn[DQ_TOGGLE_ONE];
                            if (flashDqIn[DQ_TIMING_LIMIT])
                            begin
                                pollStep <= 2'h2;
                                timingSeen <= 1'b1;
                            end
                            nextOp <= OP_READ;
                        end
                    end
                end
                BUS_WRITE:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt == WE_CYC - 8'h01)
                    begin
                        cnt <= 8'h00;
                        flashWeN <= 1'b1;
                        flashCeN <= 1'b1;
                        done <= !fail;
                        nextOp <= OP_NONE;
                        busState <= BUS_GAP;
                    end
                end
                default:
                begin
                    // Data stays driven through the gap to give hold time after WE rises.
                    cnt <= cnt + 8'h01;
                    if (cnt == GAP_CYC - 8'h01)
                    begin
                        cnt <= 8'h00;
                        flashDqOe <= 1'b0;
                        if (nextOp == OP_READ)
                        begin
                            busState <= BUS_READ;
                            flashCeN <= 1'b0;
                            flashOeN <= 1'b0;
                        end
                        else if (nextOp == OP_WRITE)
                        begin
                            busState <= BUS_WRITE;
                            flashCeN <= 1'b0;
                            flashWeN <= 1'b0;
                            flashDqOe <= 1'b1;
                        end
                        else
                        begin
                            busState <= BUS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign flashAddr = addrReg;
    assign flashDqOut = wrBusData;

endmodule // fws_host

/* File: hw/fws_pkg.sv */
package fws_pkg;

    // Clock rate and flash bus timing.
    localparam int CLK_MHZ = 100;
    localparam int RD_ACCESS_NS = 70;
    localparam int WE_PULSE_NS = 35;
    localparam int BUS_GAP_NS = 20;
    localparam logic [7:0] RD_CYC = 8'((RD_ACCESS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WE_CYC = 8'((WE_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] GAP_CYC = 8'((BUS_GAP_NS * CLK_MHZ + 999) / 1000);

    // Register offsets of the controller.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;

    // Control bits (write one to start, or to abort for CTRL_ABORT).
    localparam int CTRL_POLL = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_WRITE = 2;
    localparam int CTRL_ABORT = 3;

    // Status bits.
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_ERASE_TIMER = 3;
    localparam int ST_READY = 4;
    localparam int ST_TIMING_LIMIT = 5;
    localparam int ST_BUFFER_ABORT = 6;
    localparam int ST_DATA_POLL = 7;

    // Status bit positions on the flash data bus.
    localparam int DQ_DATA_POLL = 7;
    localparam int DQ_TOGGLE_ONE = 6;
    localparam int DQ_TIMING_LIMIT = 5;
    localparam int DQ_ERASE_TIMER = 3;
    localparam int DQ_TOGGLE_TWO = 2;
    localparam int DQ_BUFFER_ABORT = 1;

    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE, BUS_GAP} fws_bus_type;
    typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} fws_op_type;

endpackage

/* File: tb/fws_host_sva.sv */
`timescale 1ns/1ns
module fws_host_chk
    import fws_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Watched ports.
    input wire logic [21:0] flashAddr,
    input wire logic flashDqOe,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_READ_STROBES: assert property (!flashOeN |-> !flashCeN && flashWeN && !flashDqOe)
        else $error("Bad strobes in read.");
    AST_READ_LEN: assert property ($fell(flashOeN) |-> !flashOeN [*7] ##1 flashOeN)
        else $error("Read length wrong.");
    AST_READ_GAP: assert property ($rose(flashOeN) |-> flashOeN [*2])
        else $error("Read gap short.");
    AST_WE_LEN: assert property ($fell(flashWeN) |-> (!flashWeN && !flashCeN) [*4] ##1 flashWeN)
        else $error("Write length wrong.");
    AST_WE_DRIVE: assert property (!flashWeN |-> flashDqOe && flashOeN)
        else $error("Write without data.");
    AST_ADDR_STABLE: assert property (!flashOeN && $past(!flashOeN) |-> $stable(flashAddr))
        else $error("Address moved in read.");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write answer dropped.");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("Read answer dropped.");
    COV_READ: cover property ($fell(flashOeN));
    COV_WRITE: cover property ($fell(flashWeN));
    COV_B2B: cover property ($rose(flashOeN) ##2 $fell(flashOeN));
endmodule // fws_host_chk

/* File: tb/fws_flash_model.sv */
`timescale 1ns/1ns
module fws_flash_model (
    // Flash pins.
    input wire logic [15:0] flashDqOut,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN,
    output logic [15:0] flashDqIn,
    output logic readyBusyN,
    // Scenario control and observation.
    input wire logic load,
    input wire logic [7:0] loadCnt,
    input wire logic loadFail,
    input wire logic loadTimer,
    input wire logic [15:0] arrayData,
    output logic [15:0] readCnt,
    output logic [15:0] lastWr,
    output logic resetSeen
);
    // A toggling-read count stands for the algorithm time, so a job without loadFail stays busy for loadCnt reads.
    logic [7:0] togLeft = 8'h00;
    logic fail = 1'b0;
    logic tog = 1'b0;
    logic timer = 1'b0;
    logic busy;
    logic rdEnd;
    logic [15:0] rd;
    initial
    begin
        readCnt = 16'h0000;
        lastWr = 16'h0000;
        resetSeen = 1'b0;
    end
    assign busy = !resetSeen && (togLeft != 8'h00 || fail);
    assign rdEnd = flashCeN | flashOeN;
    assign readyBusyN = busy ? 1'b0 : 1'b1;
    assign rd = busy ? {8'h00, 1'b0, tog, fail && togLeft == 8'h00, 1'b0, timer, tog, 2'b00}
        : arrayData;
    // A released bus shows the inverse so that a late sample never matches by luck.
    assign flashDqIn = rdEnd ? ~rd : rd;
    always @(posedge rdEnd or posedge load)
    begin
        if (load)
        begin
            togLeft <= loadCnt;
            fail <= loadFail;
            timer <= loadTimer;
            tog <= 1'b0;
            readCnt <= 16'h0000;
        end
        else
        begin
            readCnt <= readCnt + 16'h0001;
            if (busy) tog <= ~tog;
            if (togLeft != 8'h00) togLeft <= togLeft - 8'h01;
        end
    end
    always @(posedge flashWeN or posedge load)
    begin
        if (load) resetSeen <= 1'b0;
        else
        begin
            lastWr <= flashDqOut;
            if (flashDqOut[7:0] == 8'hF0) resetSeen <= 1'b1;
        end
    end
endmodule // fws_flash_model

/* File: tb/tb_fws_host.sv */
`timescale 1ns/1ns
module tb_fws_host
    import fws_pkg::*;
();
    logic ref_clk = 1'b0, nrst = 1'b0, load = 1'b0, mFail = 1'b0, mTimer = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, mCnt = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'h6085, rv, w;
    logic [15:0] arr = 16'h0000;
    logic [1:0] rsp;
    wire logic awready, wready, bvalid, arready, rvalid, dqOe, ceN, oeN, weN, rbN, rstSeen;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [21:0] fAddr;
    wire logic [15:0] dqOut, dqIn, readCnt, lastWr;
    int failCount = 0, checked = 0, i;
    always #5 ref_clk = ~ref_clk;
    fws_host u_dut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flashAddr(fAddr),
        .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn), .flashCeN(ceN),
        .flashOeN(oeN), .flashWeN(weN), .readyBusyN(rbN));
    fws_flash_model u_flash (.flashDqOut(dqOut), .flashCeN(ceN), .flashOeN(oeN),
        .flashWeN(weN), .flashDqIn(dqIn), .readyBusyN(rbN), .load(load), .loadCnt(mCnt),
        .loadFail(mFail), .loadTimer(mTimer), .arrayData(arr), .readCnt(readCnt),
        .lastWr(lastWr), .resetSeen(rstSeen));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic closeOut();
        $display("Comparisons %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic tmo();
        failCount++;
        $display("MISMATCH at %0t: timeout", $time);
        closeOut();
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] expDone(input logic [15:0] a);
        return {24'h0, a[7], a[1], 2'b01, a[3], 3'b010};
    endfunction
    // The model restarts its toggle bit at 0, so the last busy read of c shows !c[0].
    function automatic logic [15:0] expReads(input logic [7:0] c, input logic f,
        input logic [15:0] a);
        if (f) return (c == 8'h00) ? 16'h0003 : 16'(c) + 16'h0002;
        if (c == 8'h00) return 16'h0002;
        return (a[6] == !c[0]) ? 16'(c) + 16'h0001 : 16'(c) + 16'h0002;
    endfunction
    function automatic logic [31:0] expStat(input logic [7:0] c, input logic f, input logic t,
        input logic [15:0] a);
        if (f) return {26'h0, 2'b11, t, 3'b100};
        if (c != 8'h00 && a[6] != !c[0]) return expDone(a) | {26'h0, a[5], 5'h00};
        return expDone(a);
    endfunction
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) tmo();
    endtask
    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) tmo();
    endtask
    task automatic waitIdle();
        int k;
        for (k = 0; k < 300; k++)
        begin
            axiRd(REG_STATUS, rv, rsp);
            if (rv[ST_BUSY] === 1'b0) return;
        end
        tmo();
    endtask
    task automatic poll(input logic [7:0] c, input logic f, input logic t);
        @(posedge ref_clk);
        mCnt <= c;
        mFail <= f;
        mTimer <= t;
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        axiWr(REG_CTRL, 32'h1 << CTRL_POLL, rsp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1000000;
        tmo();
    end
    initial
    begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        axiRd(REG_STATUS, rv, rsp);
        chk(rv, 32'h10, "reset status");
        axiRd(8'h40, rv, rsp);
        chk(rsp, RESP_SLVERR, "unmapped read");
        axiWr(REG_STATUS, xs(), rsp);
        chk(rsp, RESP_SLVERR, "read-only write");
        w = xs();
        axiWr(REG_ADDR, w, rsp);
        chk(fAddr, w[21:0], "address pins");
        axiWr(REG_WDATA, w, rsp);
        axiWr(REG_CTRL, 32'h1 << CTRL_WRITE, rsp);
        waitIdle();
        chk(lastWr, w[15:0], "written word");
        arr <= 16'(xs());
        axiWr(REG_CTRL, 32'h1 << CTRL_READ, rsp);
        waitIdle();
        axiRd(REG_RDATA, rv, rsp);
        chk(rv, arr, "array read");
        for (i = 0; i < 5; i++)
        begin
            arr <= 16'(xs());
            poll((i == 0) ? 8'h00 : 8'(xs() % 12), 1'(xs()), 1'b0);
            waitIdle();
            chk(readCnt, expReads(mCnt, mFail, arr), "poll reads");
            chk(rv, expStat(mCnt, mFail, mTimer, arr), "done status");
        end
        poll(8'd200, 1'b0, 1'b1);
        axiRd(REG_STATUS, rv, rsp);
        chk(rv & 32'h11, 32'h01, "busy status");
        axiWr(REG_CTRL, 32'h1 << CTRL_ABORT, rsp);
        waitIdle();
        poll(8'h03, 1'b0, 1'b0);
        waitIdle();
        chk(readCnt, expReads(8'h03, 1'b0, arr), "restart reads");
        poll(8'h00, 1'b1, 1'b1);
        waitIdle();
        chk(readCnt, 16'h0003, "fail reads");
        chk(rv & 32'hFC, 32'h3C, "fail status");
        chk(lastWr, CMD_RESET, "reset command");
        chk(rstSeen, 1'b1, "reset taken");
        closeOut();
    end
endmodule // tb_fws_host
bind fws_host fws_host_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .flashAddr(flashAddr),
    .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
